// [rtl/ladder_reference_control.sv]
// axi4-lite register slave and control for the resistor ladder reference
`timescale 1ns/10ps
`include "ladder_reference_map.svh"

// Summary of operation
// [RULE1] power enable bit 7 powers the ladder on when 1, down when 0
// [RULE2] bit 6 routes the ladder level onto the shared pin, else disconnects
// [RULE3] while bit 6 is set the pin direction bit is ignored
// [RULE4] bit 5 high selects low range: level is tap/24 of the span
// [RULE5] bit 5 low selects high range: level is span/4 plus tap/32
// [RULE6] bit 4 picks external reference inputs when 1, supply rails when 0
// [RULE7] bits 3..0 hold the unsigned tap code, sixteen levels per range
// [RULE8] all control bits are read-write and clear on reset
// [RULE9] waking from sleep leaves the control register untouched
// [RULE10] software should clear power enable before sleep to save current
// [RULE11] the ladder runs regardless of comparator configuration
// [RULE12] software should wait for settling after changing the level
// [RULE13] ladder outputs update the cycle after the control register is written
module ladder_reference_control #(
	parameter int ADDR_WIDTH = 12
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// write address channel
	input wire logic [ADDR_WIDTH-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// write data channel
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// write response channel
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// read address channel
	input wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// read data channel
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// port a direction for the shared pin (1 = input)
	input wire logic port_a_direction_bit2,
	// to the analog ladder and pad
	output ladder_reference_pkg::ladder_settings_t ladder_settings,
	output logic [6:0] ladder_level,
	output ladder_reference_pkg::pin_ctrl_t pin_ctrl
);
	import ladder_reference_pkg::*;

	// ****************************************************************
	// elaboration check
	// ****************************************************************
	// both registers must fit the address space
	if (ADDR_WIDTH < 3 || ADDR_WIDTH > 32) begin : g_bad_width
		$error("ladder_reference_control: ADDR_WIDTH must be 3 to 32");
	end

	// ****************************************************************
	// address decode
	// ****************************************************************
	// returns {status hit, control hit}; shared by both channels
	function automatic logic [1:0] decode(input logic [ADDR_WIDTH-1:0] addr);
		decode = {addr == ADDR_WIDTH'(`LRC_STATUS_ADDR), addr == ADDR_WIDTH'(`LRC_CTRL_ADDR)};
	endfunction

	// ****************************************************************
	// state
	// ****************************************************************
	wr_state_t wr_state_ff;
	wr_state_t nxt_wr_state;
	rd_state_t rd_state_ff;
	rd_state_t nxt_rd_state;
	logic aw_held_ff;
	logic w_held_ff;
	logic [ADDR_WIDTH-1:0] awaddr_ff;
	logic [31:0] wdata_ff;
	logic [3:0] wstrb_ff;
	logic [1:0] bresp_ff;
	logic [31:0] rdata_ff;
	logic [1:0] rresp_ff;
	logic [7:0] ctrl_ff;
	logic [7:0] nxt_ctrl;
	logic [31:0] status_word;

	// ****************************************************************
	// write channel decode
	// ****************************************************************
	// address and data are taken in either order and held until paired
	wire wr_idle = (wr_state_ff == WR_IDLE);
	assign s_axi_awready = wr_idle && !aw_held_ff;
	assign s_axi_wready = wr_idle && !w_held_ff;
	wire aw_fire = s_axi_awvalid && s_axi_awready;
	wire w_fire = s_axi_wvalid && s_axi_wready;
	wire have_aw = aw_held_ff || aw_fire;
	wire have_w = w_held_ff || w_fire;
	wire wr_commit = wr_idle && have_aw && have_w;
	wire [ADDR_WIDTH-1:0] wr_addr = aw_held_ff ? awaddr_ff : s_axi_awaddr;
	wire [31:0] wr_data = w_held_ff ? wdata_ff : s_axi_wdata;
	wire [3:0] wr_strb = w_held_ff ? wstrb_ff : s_axi_wstrb;
	wire [1:0] wr_hit = decode(wr_addr);
	wire ctrl_write = wr_commit && wr_hit[0] && wr_strb[`LRC_CTRL_LANE];
	// status is read only: a write there is answered okay and dropped
	wire [1:0] wr_resp = (wr_hit != 2'b00) ? `LRC_RESP_OKAY : `LRC_RESP_SLVERR;
	assign s_axi_bvalid = (wr_state_ff == WR_RESP);
	assign s_axi_bresp = bresp_ff;

	// only a bus write changes the byte; sleep and wake have no path in [RULE9]
	assign nxt_ctrl = ctrl_write ? wr_data[`LRC_CTRL_MSB:0] : ctrl_ff; // [RULE8]

	// write state: one write outstanding, response held until bready
	always_comb begin
		nxt_wr_state = wr_state_ff;
		case (wr_state_ff)
			WR_IDLE: begin
				if (wr_commit) begin
					nxt_wr_state = WR_RESP;
				end
			end
			WR_RESP: begin
				if (s_axi_bready) begin
					nxt_wr_state = WR_IDLE;
				end
			end
			default: begin
				nxt_wr_state = WR_IDLE;
			end
		endcase
	end

	// write channel registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wr_state_ff <= WR_IDLE;
			aw_held_ff <= 1'b0;
			w_held_ff <= 1'b0;
			awaddr_ff <= '0;
			wdata_ff <= `LRC_DATA_RESET;
			wstrb_ff <= '0;
			bresp_ff <= `LRC_RESP_OKAY;
		end else begin
			wr_state_ff <= nxt_wr_state;
			aw_held_ff <= !wr_commit && have_aw;
			w_held_ff <= !wr_commit && have_w;
			if (aw_fire) begin
				awaddr_ff <= s_axi_awaddr;
			end
			if (w_fire) begin
				wdata_ff <= s_axi_wdata;
				wstrb_ff <= s_axi_wstrb;
			end
			if (wr_commit) begin
				bresp_ff <= wr_resp;
			end
		end
	end

	// control register, cleared by reset
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_ff <= `LRC_CTRL_RESET; // [RULE8]
		end else begin
			ctrl_ff <= nxt_ctrl;
		end
	end

	// ****************************************************************
	// read channel
	// ****************************************************************
	// status shows what the ladder is really being fed, not the byte
	always_comb begin
		status_word = `LRC_STATUS_RESET;
		status_word[`LRC_ST_LEVEL_MSB:`LRC_ST_LEVEL_LSB] = ladder_level;
		status_word[`LRC_ST_POWERED_BIT] = ladder_settings.ladder_power_enable;
		status_word[`LRC_ST_CONNECT_BIT] = pin_ctrl.analog_connect;
		status_word[`LRC_ST_DIGITAL_OE_BIT] = pin_ctrl.digital_oe;
	end

	assign s_axi_arready = (rd_state_ff == RD_IDLE);
	wire ar_fire = s_axi_arvalid && s_axi_arready;
	wire [1:0] rd_hit = decode(s_axi_araddr);
	wire [31:0] rd_word = rd_hit[0] ? {24'h00_0000, ctrl_ff} :
		(rd_hit[1] ? status_word : `LRC_DATA_RESET);
	wire [1:0] rd_resp = (rd_hit != 2'b00) ? `LRC_RESP_OKAY : `LRC_RESP_SLVERR;
	assign s_axi_rvalid = (rd_state_ff == RD_DATA);
	assign s_axi_rdata = rdata_ff;
	assign s_axi_rresp = rresp_ff;

	// read state: one read outstanding, data held until rready
	always_comb begin
		nxt_rd_state = rd_state_ff;
		case (rd_state_ff)
			RD_IDLE: begin
				if (ar_fire) begin
					nxt_rd_state = RD_DATA;
				end
			end
			RD_DATA: begin
				if (s_axi_rready) begin
					nxt_rd_state = RD_IDLE;
				end
			end
			default: begin
				nxt_rd_state = RD_IDLE;
			end
		endcase
	end

	// read channel registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rd_state_ff <= RD_IDLE;
			rdata_ff <= `LRC_DATA_RESET;
			rresp_ff <= `LRC_RESP_OKAY;
		end else begin
			rd_state_ff <= nxt_rd_state;
			if (ar_fire) begin
				rdata_ff <= rd_word;
				rresp_ff <= rd_resp;
			end
		end
	end

	// ****************************************************************
	// analog side
	// ****************************************************************
	// outputs lag the control byte by one edge [RULE13]
	ladder_output_stage u_output_stage (
		.aclk(aclk),
		.aresetn(aresetn),
		.ctrl_value(ctrl_ff),
		.port_a_direction_bit2(port_a_direction_bit2),
		.ladder_settings_ff(ladder_settings),
		.ladder_level_ff(ladder_level),
		.pin_ctrl_ff(pin_ctrl)
	);

	// ****************************************************************
	// checks
	// ****************************************************************
	chk_ctrl_reset_zero: assert property (@(posedge aclk) disable iff (1'b0) // [RULE8]
		!aresetn |=> ctrl_ff == `LRC_CTRL_RESET)
		else $error("control byte not cleared by reset");

	chk_reset_outputs: assert property (@(posedge aclk) disable iff (1'b0) // [RULE8]
		!aresetn ##1 !aresetn |=> ladder_settings == ladder_settings_t'(`LRC_CTRL_RESET))
		else $error("ladder settings not cleared by reset");

	chk_write_stores: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE8]
		ctrl_write |=> ctrl_ff == $past(wr_data[`LRC_CTRL_MSB:0]))
		else $error("control write not stored");

	chk_ctrl_holds: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE9]
		!ctrl_write |=> $stable(ctrl_ff))
		else $error("control byte changed without a write");

	chk_outputs_follow: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE13]
		ctrl_write ##1 !ctrl_write |=> ladder_settings == ladder_settings_t'($past(ctrl_ff)))
		else $error("ladder settings did not follow the write");

	chk_power_on: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE1]
		ctrl_write && wr_data[`LRC_POWER_BIT] ##1 !ctrl_write
		|=> ladder_settings.ladder_power_enable)
		else $error("ladder not powered after enable write");

	chk_power_off: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE1]
		ctrl_write && !wr_data[`LRC_POWER_BIT] ##1 !ctrl_write
		|=> !ladder_settings.ladder_power_enable)
		else $error("ladder still powered after disable write");

	chk_level_low: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE4]
		ladder_settings.low_range_select
		|-> ladder_level == 7'({3'h0, ladder_settings.tap_code} * `LRC_LOW_STEP))
		else $error("low range level wrong");

	chk_level_high: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE5]
		!ladder_settings.low_range_select |-> ladder_level
		== 7'(`LRC_HIGH_BASE + {3'h0, ladder_settings.tap_code} * `LRC_HIGH_STEP))
		else $error("high range level wrong");

	chk_source_select: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE6]
		$changed(ladder_settings.external_source_select)
		|-> ladder_settings.external_source_select == $past(ctrl_ff[`LRC_EXT_SOURCE_BIT]))
		else $error("source select changed without the control bit");

	chk_tap_code: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE7]
		ladder_settings.tap_code == $past(ctrl_ff[`LRC_TAP_MSB:`LRC_TAP_LSB]))
		else $error("tap code does not match the control byte");

	chk_bresp_follows: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_commit |=> s_axi_bvalid && s_axi_bresp == $past(wr_resp))
		else $error("write response missing after commit");

	chk_unmapped_read: assert property (@(posedge aclk) disable iff (!aresetn)
		ar_fire && rd_hit == 2'b00 |=> s_axi_rvalid && s_axi_rresp == `LRC_RESP_SLVERR)
		else $error("unmapped read not answered with slverr");

	cov_ctrl_write: cover property (@(posedge aclk) disable iff (!aresetn) ctrl_write);

	cov_low_range_on: cover property (@(posedge aclk) disable iff (!aresetn)
		ladder_settings.ladder_power_enable && ladder_settings.low_range_select);

	cov_pin_override: cover property (@(posedge aclk) disable iff (!aresetn)
		pin_ctrl.analog_connect && !port_a_direction_bit2);

	cov_status_read: cover property (@(posedge aclk) disable iff (!aresetn)
		ar_fire && rd_hit[1]);

endmodule

// [rtl/ladder_reference_map.svh]
// register offsets, field positions, reset values and ladder constants
`ifndef LADDER_REFERENCE_MAP_SVH
`define LADDER_REFERENCE_MAP_SVH

// ****************************************************************
// register byte addresses
// ****************************************************************
`define LRC_CTRL_ADDR 32'h0000_0000
`define LRC_STATUS_ADDR 32'h0000_0004

// ****************************************************************
// control register fields
// ****************************************************************
`define LRC_CTRL_RESET 8'h00
`define LRC_POWER_BIT 7
`define LRC_PIN_DRIVE_BIT 6
`define LRC_LOW_RANGE_BIT 5
`define LRC_EXT_SOURCE_BIT 4
`define LRC_TAP_MSB 3
`define LRC_TAP_LSB 0
`define LRC_CTRL_MSB 7
`define LRC_CTRL_LANE 0

// ****************************************************************
// status register fields
// ****************************************************************
`define LRC_ST_LEVEL_MSB 6
`define LRC_ST_LEVEL_LSB 0
`define LRC_ST_POWERED_BIT 8
`define LRC_ST_CONNECT_BIT 9
`define LRC_ST_DIGITAL_OE_BIT 10
`define LRC_STATUS_RESET 32'h0000_0000

// ****************************************************************
// ladder level in 1/96 of the source span
// ****************************************************************
`define LRC_HIGH_BASE 7'h18
`define LRC_LOW_STEP 7'h04
`define LRC_HIGH_STEP 7'h03
`define LRC_LEVEL_RESET 7'h18

// ****************************************************************
// bus answers
// ****************************************************************
`define LRC_RESP_OKAY 2'b00
`define LRC_RESP_SLVERR 2'b10
`define LRC_DATA_RESET 32'h0000_0000

`endif

// [rtl/ladder_reference_pkg.sv]
// types shared by the ladder reference control block
package ladder_reference_pkg;

	// ****************************************************************
	// ladder settings, laid out as the control byte (msb first)
	// ****************************************************************
	typedef struct packed {
		logic ladder_power_enable;
		logic reference_pin_drive_enable;
		logic low_range_select;
		logic external_source_select;
		logic [3:0] tap_code;
	} ladder_settings_t;

	// shared pin pad control
	typedef struct packed {
		logic analog_connect;
		logic digital_oe;
	} pin_ctrl_t;

	// ****************************************************************
	// bus channel states
	// ****************************************************************
	typedef enum logic [1:0] {
		WR_IDLE = 2'b01,
		WR_RESP = 2'b10
	} wr_state_t;

	typedef enum logic [1:0] {
		RD_IDLE = 2'b01,
		RD_DATA = 2'b10
	} rd_state_t;

endpackage

// [rtl/ladder_output_stage.sv]
// registered settings, level code and pin control handed to the analog ladder
`timescale 1ns/10ps
`include "ladder_reference_map.svh"

module ladder_output_stage (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// control byte and port direction
	input wire logic [7:0] ctrl_value,
	input wire logic port_a_direction_bit2,
	// to the analog ladder and pad
	output ladder_reference_pkg::ladder_settings_t ladder_settings_ff,
	output logic [6:0] ladder_level_ff,
	output ladder_reference_pkg::pin_ctrl_t pin_ctrl_ff
);
	import ladder_reference_pkg::*;

	// ****************************************************************
	// level decode
	// ****************************************************************
	// level in 1/96 of span: low range tap/24, high range 1/4 + tap/32
	function automatic logic [6:0] level_of(input logic low, input logic [3:0] tap);
		logic [6:0] wide_tap;
		wide_tap = {3'h0, tap};
		if (low) begin
			level_of = 7'(wide_tap * `LRC_LOW_STEP); // [RULE4]
		end else begin
			level_of = 7'(`LRC_HIGH_BASE + wide_tap * `LRC_HIGH_STEP); // [RULE5]
		end
	endfunction

	ladder_settings_t nxt_settings;
	pin_ctrl_t nxt_pin;
	logic [6:0] nxt_level;

	// field split; comparator state never enters, so the ladder runs alone [RULE11]
	assign nxt_settings.ladder_power_enable = ctrl_value[`LRC_POWER_BIT]; // [RULE1]
	assign nxt_settings.reference_pin_drive_enable = ctrl_value[`LRC_PIN_DRIVE_BIT]; // [RULE2]
	assign nxt_settings.low_range_select = ctrl_value[`LRC_LOW_RANGE_BIT];
	assign nxt_settings.external_source_select = ctrl_value[`LRC_EXT_SOURCE_BIT]; // [RULE6]
	assign nxt_settings.tap_code = ctrl_value[`LRC_TAP_MSB:`LRC_TAP_LSB]; // [RULE7]
	assign nxt_level = level_of(nxt_settings.low_range_select, nxt_settings.tap_code);

	// pin drive wins over the direction bit (1 = input)
	assign nxt_pin.analog_connect = nxt_settings.reference_pin_drive_enable; // [RULE2]
	assign nxt_pin.digital_oe = !nxt_settings.reference_pin_drive_enable
		&& !port_a_direction_bit2; // [RULE3]

	// ****************************************************************
	// output registers
	// ****************************************************************
	// one stage after the control register, keeps analog inputs glitch free
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ladder_settings_ff <= ladder_settings_t'(`LRC_CTRL_RESET);
			ladder_level_ff <= `LRC_LEVEL_RESET;
			pin_ctrl_ff <= '0;
		end else begin
			ladder_settings_ff <= nxt_settings; // [RULE13]
			ladder_level_ff <= nxt_level;
			pin_ctrl_ff <= nxt_pin;
		end
	end

	// ****************************************************************
	// checks
	// ****************************************************************
	chk_pin_override: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE3]
		ladder_settings_ff.reference_pin_drive_enable |-> !pin_ctrl_ff.digital_oe)
		else $error("pin digital drive active while reference drives it");

	chk_pin_route: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE2]
		pin_ctrl_ff.analog_connect == ladder_settings_ff.reference_pin_drive_enable)
		else $error("pin analog switch disagrees with drive enable");

endmodule

// [verif/ladder_reference_control_tb.sv]
// self-checking testbench for the ladder reference control block
`timescale 1ns/10ps
`include "ladder_reference_map.svh"

module ladder_reference_control_tb;
	import ladder_reference_pkg::*;

	// ****************************************************************
	// signals
	// ****************************************************************
	logic aclk, aresetn;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [2:0] s_axi_awprot, s_axi_arprot;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic port_a_direction_bit2;
	ladder_settings_t ladder_settings;
	logic [6:0] ladder_level;
	pin_ctrl_t pin_ctrl;
	int errors, checks_done;
	logic [1:0] bq[$];
	logic [33:0] rq[$];
	logic [31:0] rnd;
	logic [7:0] cur;

	ladder_reference_control ladder_reference_control_i (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(s_axi_awprot),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arprot(s_axi_arprot),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.port_a_direction_bit2(port_a_direction_bit2),
		.ladder_settings(ladder_settings), .ladder_level(ladder_level), .pin_ctrl(pin_ctrl)
	);

	// ****************************************************************
	// clock, helpers and expectations
	// ****************************************************************
	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end

	function automatic logic [31:0] lfsr_next(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction

	// level in 1/96 of the span: /24 is 4 units, /32 is 3 units, a quarter is 24
	function automatic logic [6:0] level_exp(input logic [7:0] c);
		return c[5] ? {3'h0, c[3:0]} * 7'h04 : 7'h18 + {3'h0, c[3:0]} * 7'h03;
	endfunction

	function automatic logic [31:0] status_exp(input logic [7:0] c, input logic dir);
		return {21'h0, ~c[6] & ~dir, c[6], c[7], 1'b0, level_exp(c)};
	endfunction

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			errors++;
			$display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask

	task automatic final_report;
		$display("errors=%0d checks_done=%0d", errors, checks_done);
		if (errors == 0 && checks_done > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// ****************************************************************
	// bus master tasks, entered right after a rising edge
	// ****************************************************************
	// gap idles a few cycles first; address and data are offered together,
	// and only the watchdog ends a wait that never gets its answer
	task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
		input logic [1:0] er, input int gap);
		repeat (gap) @(posedge aclk);
		bq.push_back(er);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_wvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!(s_axi_bvalid && s_axi_bready));
	endtask

	task automatic axi_read(input logic [11:0] a, input logic [1:0] er, input logic [31:0] ed);
		rq.push_back({er, ed});
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!(s_axi_rvalid && s_axi_rready));
	endtask

	// outputs looked at once settled, then back onto the edge
	task automatic check_outputs(input logic [7:0] c, input logic dir);
		#1;
		check({24'h0, ladder_settings}, {24'h0, c});
		check({25'h0, ladder_level}, {25'h0, level_exp(c)});
		check({30'h0, pin_ctrl}, {30'h0, c[6], ~c[6] & ~dir});
		@(posedge aclk);
	endtask

	task automatic do_reset;
		aresetn <= 1'b0;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		cur = 8'h00;
	endtask

	// ****************************************************************
	// response monitor: each answer against the oldest note
	// ****************************************************************
	always @(posedge aclk) begin
		if (s_axi_bvalid && s_axi_bready) begin
			if (bq.size() == 0) check(32'h0, 32'h3);
			else check({30'h0, s_axi_bresp}, {30'h0, bq.pop_front()});
		end
		if (s_axi_rvalid && s_axi_rready) begin
			if (rq.size() == 0) begin
				check(32'h0, 32'h4);
			end else begin
				check({30'h0, s_axi_rresp}, {30'h0, rq[0][33:32]});
				check(s_axi_rdata, rq[0][31:0]);
				rq.delete(0);
			end
		end
	end

	// hang guard, far beyond the few hundred cycles the run needs
	initial begin
		repeat (20000) @(posedge aclk);
		check(32'h0, 32'h5);
		final_report;
	end

	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial begin
		errors = 0;
		checks_done = 0;
		rnd = 32'hce07bfd0;
		s_axi_awaddr <= 12'h000;
		s_axi_araddr <= 12'h000;
		s_axi_awprot <= 3'h0;
		s_axi_arprot <= 3'h0;
		s_axi_awvalid <= 1'b0;
		s_axi_wvalid <= 1'b0;
		s_axi_arvalid <= 1'b0;
		s_axi_wdata <= 32'h0;
		s_axi_wstrb <= 4'h0;
		s_axi_bready <= 1'b1;
		s_axi_rready <= 1'b1;
		port_a_direction_bit2 <= 1'b0;
		do_reset;
		check_outputs(8'h00, 1'b0);
		axi_read(12'h000, `LRC_RESP_OKAY, 32'h0);
		axi_read(12'h004, `LRC_RESP_OKAY, status_exp(8'h00, 1'b0));
		// every tap in both ranges, all drive and direction pairs, random rest
		for (int i = 0; i < 32; i++) begin
			rnd = lfsr_next(rnd);
			cur = {rnd[7], i[1], i[4], rnd[4], i[3:0]};
			port_a_direction_bit2 <= i[0];
			s_axi_awprot <= rnd[10:8];
			s_axi_arprot <= rnd[13:11];
			axi_write(12'h000, {rnd[31:8], cur}, 4'hf, `LRC_RESP_OKAY, i % 3);
			check_outputs(cur, i[0]);
			axi_read(12'h000, `LRC_RESP_OKAY, {24'h0, cur});
			axi_read(12'h004, `LRC_RESP_OKAY, status_exp(cur, i[0]));
		end
		// masked lane, status write and unmapped places change nothing
		axi_write(12'h000, 32'hff, 4'he, `LRC_RESP_OKAY, 0);
		axi_write(12'h004, 32'hffffffff, 4'hf, `LRC_RESP_OKAY, 1);
		axi_write(12'h008, 32'hff, 4'hf, `LRC_RESP_SLVERR, 0);
		axi_read(12'hffc, `LRC_RESP_SLVERR, 32'h0);
		axi_read(12'h000, `LRC_RESP_OKAY, {24'h0, cur});
		check_outputs(cur, 1'b1);
		// long idle with power cleared first, as software does before sleep
		cur = 8'h6b;
		axi_write(12'h000, {24'h0, cur}, 4'h1, `LRC_RESP_OKAY, 2);
		repeat (200) @(posedge aclk);
		check_outputs(cur, 1'b1);
		axi_read(12'h000, `LRC_RESP_OKAY, {24'h0, cur});
		// settings fully set, then a reset in mid-run clears them all
		axi_write(12'h000, 32'hff, 4'h1, `LRC_RESP_OKAY, 0);
		check_outputs(8'hff, 1'b1);
		do_reset;
		check_outputs(8'h00, 1'b1);
		axi_read(12'h000, `LRC_RESP_OKAY, 32'h0);
		repeat (4) @(posedge aclk);
		if (bq.size() != 0 || rq.size() != 0) check(32'h0, 32'h6);
		final_report;
	end
endmodule
